// ===== src/olap_regs.sv
// write-only display attribute and area plane register bank
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
`include "olap_consts.svh"

// Overview of operation
// - size code 01 large, 11 small
// - size code 00 off, 10 middle
// - one underline enable per row
// - one fringing enable per row
// - two-bit solid space: none/left/right/both
// - three background colour bits
// - area one colour in low nibble
// - area two colour in high nibble
// - bit 3 makes area one half transparent
// - bit 7 makes area two half transparent
// - bit 4 enables area one plane
// - bit 5 enables area two plane
// - area one horizontal start, nine bits
// - area one horizontal end, nine bits
// - area one vertical start, ten bits
// - area one vertical end, ten bits
// - area two horizontal start, nine bits
module olap_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic      [7:0]  o_row_char_size,
  output logic      [3:0]  o_row_off,
  output logic      [3:0]  o_row_large,
  output logic      [3:0]  o_row_middle,
  output logic      [3:0]  o_row_small,
  output logic      [11:0] o_row_underline_en,
  output logic      [11:0] o_row_fringe_en,
  output logic      [11:0] o_row_solid_left,
  output logic      [11:0] o_row_solid_right,
  output logic      [2:0]  o_bg_rgb,
  output logic      [2:0]  o_plane1_rgb,
  output logic      [2:0]  o_plane2_rgb,
  output logic             o_plane1_half_transparent,
  output logic             o_plane2_half_transparent,
  output logic             o_background_func_en,
  output logic             o_full_raster_blank,
  output logic             o_plane1_show,
  output logic             o_plane2_show,
  output logic      [2:0]  o_raster_rgb,
  output logic      [8:0]  o_plane1_h_start,
  output logic      [8:0]  o_plane1_h_end,
  output logic      [9:0]  o_plane1_v_start,
  output logic      [9:0]  o_plane1_v_end,
  output logic      [8:0]  o_plane2_h_start
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // full sixteen-bit compare, so no mirror of the bank answers a write
  function automatic logic wr_hit(input logic [15:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction

  function automatic olap_pkg::olap_size_e size_of(input logic [1:0] code);
    size_of = olap_pkg::olap_size_e'(code);
  endfunction

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // nothing is stored for reading, so software must shadow its writes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_rdata <= `OLAP_READ_ANSWER;
    end else begin
      o_rdata <= `OLAP_READ_ANSWER;
    end
  end

  // ----------------------------------------------------------------
  // character size, rows nine to twelve
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_row_char_size <= `OLAP_RST_BYTE;
    end else if (wr_hit(`OLAP_ADDR_CSIZE_9_12)) begin
      o_row_char_size <= i_wdata;
    end
  end

  // decoded per row so the display engine needs no comparators
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_size
      logic off_q;
      logic large_q;
      logic middle_q;
      logic small_q;
      // a row stays off until software picks a size for it
      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
          off_q    <= 1'b1;
          large_q  <= 1'b0;
          middle_q <= 1'b0;
          small_q  <= 1'b0;
        end else if (wr_hit(`OLAP_ADDR_CSIZE_9_12)) begin
          off_q    <= size_of(i_wdata[2*g+:2]) == olap_pkg::OLAP_SIZE_OFF;
          large_q  <= size_of(i_wdata[2*g+:2]) == olap_pkg::OLAP_SIZE_LARGE;
          middle_q <= size_of(i_wdata[2*g+:2]) == olap_pkg::OLAP_SIZE_MIDDLE;
          small_q  <= size_of(i_wdata[2*g+:2]) == olap_pkg::OLAP_SIZE_SMALL;
        end
      end
      assign o_row_off[g]    = off_q;
      assign o_row_large[g]  = large_q;
      assign o_row_middle[g] = middle_q;
      assign o_row_small[g]  = small_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // underline and fringing enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_row_underline_en <= `OLAP_RST_ROWS;
    end else if (wr_hit(`OLAP_ADDR_UL_1_8)) begin
      o_row_underline_en[7:0] <= i_wdata;
    end else if (wr_hit(`OLAP_ADDR_UL_9_12)) begin
      o_row_underline_en[11:8] <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_row_fringe_en <= `OLAP_RST_ROWS;
    end else if (wr_hit(`OLAP_ADDR_FR_1_8)) begin
      o_row_fringe_en[7:0] <= i_wdata;
    end else if (wr_hit(`OLAP_ADDR_FR_9_12)) begin
      o_row_fringe_en[11:8] <= i_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // solid space, four rows per byte
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 12; g++) begin : g_sol
      localparam logic [15:0] SOL_ADDR = `OLAP_ADDR_SOL_1_4 + 16'(g / 4);
      localparam int unsigned SOL_LSB  = 2 * (g % 4);
      logic left_q;
      logic right_q;
      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
          left_q  <= 1'b0;
          right_q <= 1'b0;
        end else if (wr_hit(SOL_ADDR)) begin
          left_q  <= i_wdata[SOL_LSB+`OLAP_SOL_LEFT_BIT];
          right_q <= i_wdata[SOL_LSB+`OLAP_SOL_RIGHT_BIT];
        end
      end
      assign o_row_solid_left[g]  = left_q;
      assign o_row_solid_right[g] = right_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // colours
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_bg_rgb <= `OLAP_RST_RGB;
    end else if (wr_hit(`OLAP_ADDR_BG_COLOUR)) begin
      o_bg_rgb <= {i_wdata[`OLAP_BG_RED_BIT], i_wdata[`OLAP_BG_GREEN_BIT], i_wdata[`OLAP_BG_BLUE_BIT]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_plane1_rgb              <= `OLAP_RST_RGB;
      o_plane2_rgb              <= `OLAP_RST_RGB;
      o_plane1_half_transparent <= 1'b0;
      o_plane2_half_transparent <= 1'b0;
    end else if (wr_hit(`OLAP_ADDR_AREA_COLOUR)) begin
      o_plane1_rgb              <= i_wdata[`OLAP_P1_RGB_LSB+:3];
      o_plane2_rgb              <= i_wdata[`OLAP_P2_RGB_LSB+:3];
      o_plane1_half_transparent <= i_wdata[`OLAP_P1_HALF_BIT];
      o_plane2_half_transparent <= i_wdata[`OLAP_P2_HALF_BIT];
    end
  end

  // ----------------------------------------------------------------
  // raster plane control
  // ----------------------------------------------------------------
  // planes come up hidden so nothing shows before software sets positions
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_background_func_en <= 1'b0;
      o_full_raster_blank  <= 1'b0;
      o_plane1_show        <= 1'b0;
      o_plane2_show        <= 1'b0;
      o_raster_rgb         <= `OLAP_RST_RGB;
    end else if (wr_hit(`OLAP_ADDR_RASTER_CTL)) begin
      o_background_func_en <= i_wdata[`OLAP_BG_FUNC_BIT];
      o_full_raster_blank  <= i_wdata[`OLAP_BLANK_BIT];
      o_plane1_show        <= i_wdata[`OLAP_P1_SHOW_BIT];
      o_plane2_show        <= i_wdata[`OLAP_P2_SHOW_BIT];
      o_raster_rgb         <= i_wdata[`OLAP_RASTER_RGB_LSB+:3];
    end
  end

  // ----------------------------------------------------------------
  // area plane positions
  // ----------------------------------------------------------------
  // halves load separately; the engine may briefly see a mixed value
  olap_posreg #(.HI_W(1)) u_p1_hs (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (wr_hit(`OLAP_ADDR_A1_HS)),
    .i_wr_hi   (wr_hit(`OLAP_ADDR_A1_HS + `OLAP_HI_BYTE_STEP)),
    .i_wdata   (i_wdata),
    .o_pos     (o_plane1_h_start)
  );

  olap_posreg #(.HI_W(1)) u_p1_he (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (wr_hit(`OLAP_ADDR_A1_HE)),
    .i_wr_hi   (wr_hit(`OLAP_ADDR_A1_HE + `OLAP_HI_BYTE_STEP)),
    .i_wdata   (i_wdata),
    .o_pos     (o_plane1_h_end)
  );

  olap_posreg #(.HI_W(2)) u_p1_vs (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (wr_hit(`OLAP_ADDR_A1_VS)),
    .i_wr_hi   (wr_hit(`OLAP_ADDR_A1_VS + `OLAP_HI_BYTE_STEP)),
    .i_wdata   (i_wdata),
    .o_pos     (o_plane1_v_start)
  );

  olap_posreg #(.HI_W(2)) u_p1_ve (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (wr_hit(`OLAP_ADDR_A1_VE)),
    .i_wr_hi   (wr_hit(`OLAP_ADDR_A1_VE + `OLAP_HI_BYTE_STEP)),
    .i_wdata   (i_wdata),
    .o_pos     (o_plane1_v_end)
  );

  olap_posreg #(.HI_W(1)) u_p2_hs (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (wr_hit(`OLAP_ADDR_A2_HS)),
    .i_wr_hi   (wr_hit(`OLAP_ADDR_A2_HS + `OLAP_HI_BYTE_STEP)),
    .i_wdata   (i_wdata),
    .o_pos     (o_plane2_h_start)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  size_large_small_a: assert property (
    wr_hit(`OLAP_ADDR_CSIZE_9_12) |=>
      (o_row_large[0] == ($past(i_wdata[1:0]) == 2'h1)) && (o_row_small[3] == ($past(i_wdata[7:6]) == 2'h3)))
    else $error("row size large or small decode wrong");

  size_off_middle_a: assert property (
    wr_hit(`OLAP_ADDR_CSIZE_9_12) && i_wdata[3:2] == 2'h0 && i_wdata[5:4] == 2'h2 |=>
      o_row_off[1] && !o_row_middle[1] && o_row_middle[2] && !o_row_off[2])
    else $error("row size off or middle decode wrong");

  size_onehot_a: assert property (
    ##1 (o_row_off | o_row_large | o_row_middle | o_row_small) == 4'hF
      && (o_row_off & (o_row_large | o_row_middle | o_row_small)) == 4'h0
      && (o_row_large & (o_row_middle | o_row_small)) == 4'h0
      && (o_row_middle & o_row_small) == 4'h0)
    else $error("row size decode not exclusive");

  underline_hi_a: assert property (
    wr_hit(`OLAP_ADDR_UL_9_12) |=> o_row_underline_en[11:8] == $past(i_wdata[3:0])
      && $stable(o_row_underline_en[7:0]))
    else $error("underline rows nine to twelve wrong");

  fringe_lo_a: assert property (
    wr_hit(`OLAP_ADDR_FR_1_8) |=> o_row_fringe_en[7:0] == $past(i_wdata) && $stable(o_row_fringe_en[11:8]))
    else $error("fringing rows one to eight wrong");

  solid_space_a: assert property (
    wr_hit(`OLAP_ADDR_SOL_5_8) && i_wdata[7:6] == 2'h1 && i_wdata[1:0] == 2'h2 |=>
      o_row_solid_left[7] && !o_row_solid_right[7] && o_row_solid_right[4] && !o_row_solid_left[4])
    else $error("solid space decode wrong");

  bg_colour_a: assert property (
    wr_hit(`OLAP_ADDR_BG_COLOUR) |=> o_bg_rgb == $past(i_wdata[6:4]))
    else $error("background colour wrong");

  area_colour_a: assert property (
    wr_hit(`OLAP_ADDR_AREA_COLOUR) |=> o_plane1_rgb == $past(i_wdata[2:0]) && o_plane2_rgb == $past(i_wdata[6:4]))
    else $error("area plane colour wrong");

  half_transp_a: assert property (
    wr_hit(`OLAP_ADDR_AREA_COLOUR) |=>
      o_plane1_half_transparent == $past(i_wdata[3]) && o_plane2_half_transparent == $past(i_wdata[7]))
    else $error("half transparency select wrong");

  plane_show_a: assert property (
    wr_hit(`OLAP_ADDR_RASTER_CTL) |=> o_plane1_show == $past(i_wdata[4]) && o_plane2_show == $past(i_wdata[5]))
    else $error("area plane enable wrong");

  raster_ctl_a: assert property (
    wr_hit(`OLAP_ADDR_RASTER_CTL) |=> o_raster_rgb == $past(i_wdata[2:0])
      && o_background_func_en == $past(i_wdata[7]) && o_full_raster_blank == $past(i_wdata[6]))
    else $error("raster control bits wrong");

  // back-to-back high-byte writes must not bleed between the two planes
  h_start_hi_a: assert property (
    wr_hit(16'h0FA9) ##1 wr_hit(16'h0FB1) |=> o_plane1_h_start[8] == $past(i_wdata[0], 2)
      && o_plane2_h_start[8] == $past(i_wdata[0]))
    else $error("horizontal start high bit wrong");

  h_end_a: assert property (
    wr_hit(16'h0FAA) |=> o_plane1_h_end[7:0] == $past(i_wdata) && $stable(o_plane1_h_end[8]))
    else $error("area one horizontal end wrong");

  v_pos_a: assert property (
    wr_hit(16'h0FAD) |=> o_plane1_v_start[9:8] == $past(i_wdata[1:0]) && $stable(o_plane1_v_end))
    else $error("area one vertical position wrong");

  read_zero_a: assert property (
    i_rd |=> o_rdata == 8'h00 ##1 o_rdata == 8'h00)
    else $error("read returned stored data");

endmodule // olap_regs

`default_nettype wire

// ===== src/olap_consts.svh
// register offsets, field positions and reset values of the display attribute bank
`ifndef OLAP_CONSTS_SVH
`define OLAP_CONSTS_SVH

// ----------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------
`define OLAP_ADDR_CSIZE_9_12  16'h0F9C
`define OLAP_ADDR_UL_1_8      16'h0F9D
`define OLAP_ADDR_UL_9_12     16'h0F9E
`define OLAP_ADDR_FR_1_8      16'h0F9F
`define OLAP_ADDR_FR_9_12     16'h0FA0
`define OLAP_ADDR_SOL_1_4     16'h0FA2
`define OLAP_ADDR_SOL_5_8     16'h0FA3
`define OLAP_ADDR_SOL_9_12    16'h0FA4
`define OLAP_ADDR_BG_COLOUR   16'h0FA5
`define OLAP_ADDR_AREA_COLOUR 16'h0FA6
`define OLAP_ADDR_RASTER_CTL  16'h0FA7
`define OLAP_ADDR_A1_HS       16'h0FA8
`define OLAP_ADDR_A1_HE       16'h0FAA
`define OLAP_ADDR_A1_VS       16'h0FAC
`define OLAP_ADDR_A1_VE       16'h0FAE
`define OLAP_ADDR_A2_HS       16'h0FB0
`define OLAP_HI_BYTE_STEP     16'h0001

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OLAP_BG_RED_BIT       6
`define OLAP_BG_GREEN_BIT     5
`define OLAP_BG_BLUE_BIT      4
`define OLAP_P2_HALF_BIT      7
`define OLAP_P2_RGB_LSB       4
`define OLAP_P1_HALF_BIT      3
`define OLAP_P1_RGB_LSB       0
`define OLAP_BG_FUNC_BIT      7
`define OLAP_BLANK_BIT        6
`define OLAP_P2_SHOW_BIT      5
`define OLAP_P1_SHOW_BIT      4
`define OLAP_RASTER_RGB_LSB   0
`define OLAP_SOL_LEFT_BIT     0
`define OLAP_SOL_RIGHT_BIT    1

// ----------------------------------------------------------------
// reset values and read answer
// ----------------------------------------------------------------
`define OLAP_RST_BYTE         8'h00
`define OLAP_RST_RGB          3'h0
`define OLAP_RST_ROWS         12'h000
`define OLAP_READ_ANSWER      8'h00

`endif

// ===== src/olap_pkg.sv
// types shared by the display attribute bank
`default_nettype none

package olap_pkg;

  // per-row character size code
  typedef enum logic [1:0] {
    OLAP_SIZE_OFF    = 2'h0,
    OLAP_SIZE_LARGE  = 2'h1,
    OLAP_SIZE_MIDDLE = 2'h2,
    OLAP_SIZE_SMALL  = 2'h3
  } olap_size_e;

  // per-row solid space code
  typedef enum logic [1:0] {
    OLAP_SOL_NONE  = 2'h0,
    OLAP_SOL_LEFT  = 2'h1,
    OLAP_SOL_RIGHT = 2'h2,
    OLAP_SOL_BOTH  = 2'h3
  } olap_sol_e;

endpackage

`default_nettype wire

// ===== src/olap_posreg.sv
// split position register: eight low bits plus a few high bits at the next byte
`default_nettype none
`include "olap_consts.svh"

module olap_posreg #(
  parameter int unsigned HI_W = 1
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic              i_wr_lo,
  input  wire logic              i_wr_hi,
  input  wire logic [7:0]        i_wdata,
  output logic      [7+HI_W:0]   o_pos
);

  // the two halves load independently; software writes them in any order
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_pos[7:0] <= `OLAP_RST_BYTE;
    end else if (i_wr_lo) begin
      o_pos[7:0] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_pos[7+HI_W:8] <= '0;
    end else if (i_wr_hi) begin
      o_pos[7+HI_W:8] <= i_wdata[HI_W-1:0];
    end
  end

endmodule // olap_posreg

`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the write-only display attribute register bank
`default_nettype none
`include "olap_consts.svh"

// ----------------------------------------------------------------
// compare helper
// ----------------------------------------------------------------
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); \
  end \
end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk_sys;
  logic        i_rstn;
  logic [15:0] i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  o_rdata, o_row_char_size;
  logic [3:0]  o_row_off, o_row_large, o_row_middle, o_row_small;
  logic [11:0] o_row_underline_en, o_row_fringe_en, o_row_solid_left, o_row_solid_right;
  logic [2:0]  o_bg_rgb, o_plane1_rgb, o_plane2_rgb, o_raster_rgb;
  logic        o_plane1_half_transparent, o_plane2_half_transparent;
  logic        o_background_func_en, o_full_raster_blank, o_plane1_show, o_plane2_show;
  logic [8:0]  o_plane1_h_start, o_plane1_h_end, o_plane2_h_start;
  logic [9:0]  o_plane1_v_start, o_plane1_v_end;
  int          miscompares;
  int          checks_done;
  int          cycles;
  logic [144:0] saved;

  // every output except o_row_off, which resets to all ones rather than zero
  wire logic [140:0] snap = {o_rdata, o_row_char_size, o_row_large, o_row_middle, o_row_small,
    o_row_underline_en, o_row_fringe_en, o_row_solid_left, o_row_solid_right, o_bg_rgb,
    o_plane1_rgb, o_plane2_rgb, o_raster_rgb, o_plane1_half_transparent,
    o_plane2_half_transparent, o_background_func_en, o_full_raster_blank, o_plane1_show,
    o_plane2_show, o_plane1_h_start, o_plane1_h_end, o_plane2_h_start, o_plane1_v_start,
    o_plane1_v_end};

  olap_regs dut (
    .i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_row_char_size,
    .o_row_off, .o_row_large, .o_row_middle, .o_row_small, .o_row_underline_en,
    .o_row_fringe_en, .o_row_solid_left, .o_row_solid_right, .o_bg_rgb, .o_plane1_rgb,
    .o_plane2_rgb, .o_plane1_half_transparent, .o_plane2_half_transparent,
    .o_background_func_en, .o_full_raster_blank, .o_plane1_show, .o_plane2_show,
    .o_raster_rgb, .o_plane1_h_start, .o_plane1_h_end, .o_plane1_v_start, .o_plane1_v_end,
    .o_plane2_h_start
  );

  always #10 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------------------------------
  // verdict and hang guard
  // ----------------------------------------------------------------
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the whole run is under a hundred cycles; this only catches a stuck sequence
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // bus tasks: write leaves its strobe up so writes can run back to back
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_rd    <= 1'b0;
    i_addr  <= a;
    i_wdata <= d;
  endtask

  task automatic idle;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic rd_zero(input logic [15:0] a);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_wr   <= 1'b0;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    `CHK("read data", 8'h00, o_rdata);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    @(posedge i_clk_sys);
    i_rstn <= 1'b0;
    i_wr   <= 1'b0;
    i_rd   <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    #1;
    `CHK("reset outputs", 141'h0, snap);
    `CHK("reset row off", 4'hF, o_row_off);
  endtask

  task automatic t_size(input logic [7:0] d, input logic [3:0] off, lg, md, sm);
    wr(`OLAP_ADDR_CSIZE_9_12, d);
    idle();
    `CHK("size byte", d, o_row_char_size);
    `CHK("size off", off, o_row_off);
    `CHK("size large", lg, o_row_large);
    `CHK("size middle", md, o_row_middle);
    `CHK("size small", sm, o_row_small);
  endtask

  task automatic t_rows;
    wr(`OLAP_ADDR_UL_1_8, 8'hA5);
    wr(`OLAP_ADDR_UL_9_12, 8'hFA);
    wr(`OLAP_ADDR_FR_1_8, 8'h5A);
    wr(`OLAP_ADDR_FR_9_12, 8'h05);
    wr(`OLAP_ADDR_SOL_1_4, 8'hE4);
    wr(`OLAP_ADDR_SOL_5_8, 8'h1B);
    wr(`OLAP_ADDR_SOL_9_12, 8'h9C);
    idle();
    `CHK("underline", 12'hAA5, o_row_underline_en);
    `CHK("fringe", 12'h55A, o_row_fringe_en);
    `CHK("solid left", 12'h65A, o_row_solid_left);
    `CHK("solid right", 12'hA3C, o_row_solid_right);
  endtask

  task automatic t_colour;
    for (int i = 0; i < 2; i++) begin
      wr(`OLAP_ADDR_BG_COLOUR, i ? 8'h50 : 8'hFF);
      wr(`OLAP_ADDR_AREA_COLOUR, i ? 8'h5A : 8'hA5);
      wr(`OLAP_ADDR_RASTER_CTL, i ? 8'h5A : 8'hA5);
      idle();
      `CHK("bg colour", i ? 3'h5 : 3'h7, o_bg_rgb);
      `CHK("plane1 colour", i ? 3'h2 : 3'h5, o_plane1_rgb);
      `CHK("plane2 colour", i ? 3'h5 : 3'h2, o_plane2_rgb);
      `CHK("plane1 half", i[0], o_plane1_half_transparent);
      `CHK("plane2 half", !i[0], o_plane2_half_transparent);
      `CHK("plane1 show", i[0], o_plane1_show);
      `CHK("plane2 show", !i[0], o_plane2_show);
      `CHK("raster colour", i ? 3'h2 : 3'h5, o_raster_rgb);
      `CHK("bg function", !i[0], o_background_func_en);
      `CHK("raster blank", i[0], o_full_raster_blank);
    end
  endtask

  task automatic t_pos;
    wr(`OLAP_ADDR_A1_HS, 8'h34);
    wr(`OLAP_ADDR_A1_HS + `OLAP_HI_BYTE_STEP, 8'hFF);
    wr(`OLAP_ADDR_A1_HE, 8'hCD);
    wr(`OLAP_ADDR_A1_HE + `OLAP_HI_BYTE_STEP, 8'hFE);
    wr(`OLAP_ADDR_A1_VS, 8'h12);
    wr(`OLAP_ADDR_A1_VS + `OLAP_HI_BYTE_STEP, 8'hFF);
    wr(`OLAP_ADDR_A1_VE, 8'h78);
    wr(`OLAP_ADDR_A1_VE + `OLAP_HI_BYTE_STEP, 8'hFE);
    wr(`OLAP_ADDR_A2_HS, 8'h9A);
    wr(`OLAP_ADDR_A2_HS + `OLAP_HI_BYTE_STEP, 8'h01);
    idle();
    `CHK("plane1 h start", 9'h134, o_plane1_h_start);
    `CHK("plane1 h end", 9'h0CD, o_plane1_h_end);
    `CHK("plane1 v start", 10'h312, o_plane1_v_start);
    `CHK("plane1 v end", 10'h278, o_plane1_v_end);
    `CHK("plane2 h start", 9'h19A, o_plane2_h_start);
    // the high half alone must leave the low byte untouched
    wr(`OLAP_ADDR_A1_HS + `OLAP_HI_BYTE_STEP, 8'h00);
    wr(`OLAP_ADDR_A2_HS + `OLAP_HI_BYTE_STEP, 8'h00);
    idle();
    `CHK("plane1 h start hi", 9'h034, o_plane1_h_start);
    `CHK("plane2 h start hi", 9'h09A, o_plane2_h_start);
  endtask

  task automatic t_unmapped;
    saved = {o_row_off, snap};
    wr(16'h0FA1, 8'hFF);
    wr(16'h0F9B, 8'hFF);
    wr(16'h1F9C, 8'hFF);
    wr(16'h0FB8, 8'hFF);
    idle();
    `CHK("unmapped writes", saved, {o_row_off, snap});
    rd_zero(`OLAP_ADDR_CSIZE_9_12);
    rd_zero(`OLAP_ADDR_RASTER_CTL);
    rd_zero(`OLAP_ADDR_A1_HS);
    rd_zero(16'h0FA1);
  endtask

  initial begin
    i_clk_sys   = 1'b0;
    i_rstn      = 1'b0;
    i_addr      = 16'h0000;
    i_wdata     = 8'h00;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    miscompares = 0;
    checks_done = 0;
    cycles      = 0;
    t_reset();
    t_size(8'hE4, 4'h1, 4'h2, 4'h4, 4'h8);
    t_size(8'h1B, 4'h8, 4'h4, 4'h2, 4'h1);
    t_size(8'h20, 4'hB, 4'h0, 4'h4, 4'h0);
    t_rows();
    t_colour();
    t_pos();
    t_unmapped();
    // a second reset at the end of the run must clear everything written above
    t_reset();
    close_out();
  end
endmodule // tb

`undef CHK
`default_nettype wire
